//--- core/cmsr_regs.sv
// clock monitor status register bank: fault and accuracy warning flags
// assumes monitor levels synchronous to core_clk; the serial front end
// decodes read commands into the command port and returns answers itself
`timescale 1ns/10ps
`include "cmsr_cfg.svh"

module cmsr_regs (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire cmsr_pkg::cmsr_fault_s fault_in,
  input wire cmsr_pkg::cmsr_warning_s warning_in,
  input wire cmsr_pkg::cmsr_cmd_s cmd,
  output logic cmd_ready,
  output cmsr_pkg::cmsr_rsp_s rsp,
  output cmsr_pkg::cmsr_byte_t fault_flags,
  output cmsr_pkg::cmsr_byte_t warning_flags,
  output logic clock_fault_pending,
  output logic clock_warning_pending
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  cmsr_pkg::cmsr_byte_t fault_set;
  cmsr_pkg::cmsr_byte_t warning_set;
  cmsr_pkg::cmsr_state_e state;
  cmsr_pkg::cmsr_state_e next_state;
  cmsr_pkg::cmsr_rsp_s next_rsp;
  logic cmd_taken;
  logic read_fault;
  logic read_warning;
  logic next_fault_pending;
  logic next_warning_pending;

  // ----------------------------------------------------------------
  // fault register bit map
  // ----------------------------------------------------------------
  always_comb begin
    fault_set = `CMSR_RESET_VALUE;
    // either monitor of the system clock sets the one shared copy
    fault_set[`CMSR_F_SYSTEM_CLOCK] = fault_in.system_clock_fault_analog |
                                      fault_in.system_clock_fault_digital;
    fault_set[`CMSR_F_STEP_UP] = fault_in.step_up_switch_clock_fault;
    fault_set[`CMSR_F_SECOND_STEP_DOWN] =
      fault_in.second_step_down_switch_clock_fault;
    fault_set[`CMSR_F_FIRST_STEP_DOWN] =
      fault_in.first_step_down_switch_clock_fault;
    fault_set[`CMSR_F_SYNC_INPUT] = fault_in.sync_input_clock_fault;
    fault_set[`CMSR_F_SWITCHER_SOURCE] = fault_in.switcher_source_clock_fault;
    fault_set[`CMSR_F_DIGITAL_SYSTEM] = fault_in.digital_system_clock_fault;
  end

  // ----------------------------------------------------------------
  // warning register bit map
  // ----------------------------------------------------------------
  always_comb begin
    warning_set = `CMSR_RESET_VALUE;
    warning_set[`CMSR_W_STEP_UP] = warning_in.step_up_switch_clock_warning;
    warning_set[`CMSR_W_SECOND_STEP_DOWN] =
      warning_in.second_step_down_switch_clock_warning;
    warning_set[`CMSR_W_FIRST_STEP_DOWN] =
      warning_in.first_step_down_switch_clock_warning;
    warning_set[`CMSR_W_SYNC_INPUT] = warning_in.sync_input_clock_warning;
    warning_set[`CMSR_W_SWITCHER_SOURCE] = warning_in.switcher_source_clock_warning;
  end

  // ----------------------------------------------------------------
  // command acceptance
  // ----------------------------------------------------------------
  // one command in flight: a read that clears must answer before the next
  // one is looked at, otherwise the confirming read could race the clear
  assign cmd_ready = (state == cmsr_pkg::CMSR_IDLE);
  assign cmd_taken = cmd.valid & cmd_ready;
  // write commands never touch the flags
  assign read_fault = cmd_taken & ~cmd.write & (cmd.sel == `CMSR_SEL_FAULT);
  assign read_warning = cmd_taken & ~cmd.write & (cmd.sel == `CMSR_SEL_WARNING);

  // ----------------------------------------------------------------
  // flag banks
  // ----------------------------------------------------------------
  cmsr_flag_bank #(
    .IMPL_MASK(`CMSR_FAULT_IMPL)
  ) u_fault_bank (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .set_in(fault_set),
    .read_pulse(read_fault),
    .flags(fault_flags)
  );

  cmsr_flag_bank #(
    .IMPL_MASK(`CMSR_WARNING_IMPL)
  ) u_warning_bank (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .set_in(warning_set),
    .read_pulse(read_warning),
    .flags(warning_flags)
  );

  // ----------------------------------------------------------------
  // answer sequencing
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_rsp = rsp;
    next_rsp.valid = 1'b0;
    unique case (state)
      cmsr_pkg::CMSR_IDLE: begin
        if (cmd_taken) begin
          next_state = cmsr_pkg::CMSR_ANSWER;
          next_rsp.valid = 1'b1;
          next_rsp.refused = cmd.write;
          if (cmd.write) begin
            next_rsp.data = `CMSR_RESET_VALUE;
          end else if (cmd.sel == `CMSR_SEL_FAULT) begin
            // value as it stood before the clearing read takes effect
            next_rsp.data = fault_flags;
          end else begin
            next_rsp.data = warning_flags;
          end
        end
      end
      cmsr_pkg::CMSR_ANSWER: begin
        next_state = cmsr_pkg::CMSR_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state <= cmsr_pkg::CMSR_IDLE;
      rsp <= '0;
    end else begin
      state <= next_state;
      rsp <= next_rsp;
    end
  end

  // ----------------------------------------------------------------
  // summary levels for the device state machine
  // ----------------------------------------------------------------
  // the masked digital system clock bit is left out: it must cause no reaction
  always_comb begin
    next_fault_pending = |(fault_flags & `CMSR_FAULT_ACTION);
    next_warning_pending = |warning_flags;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      clock_fault_pending <= 1'b0;
      clock_warning_pending <= 1'b0;
    end else begin
      clock_fault_pending <= next_fault_pending;
      clock_warning_pending <= next_warning_pending;
    end
  end

endmodule // cmsr_regs

//--- common/cmsr_cfg.svh
// constants of the clock monitor status register bank
// assumes inclusion by its bare name from the package and the design modules
`ifndef CMSR_CFG_SVH
`define CMSR_CFG_SVH

// ----------------------------------------------------------------
// register selection codes on the read command port
// ----------------------------------------------------------------
`define CMSR_SEL_FAULT 1'b0
`define CMSR_SEL_WARNING 1'b1

// ----------------------------------------------------------------
// fault register field positions
// ----------------------------------------------------------------
`define CMSR_F_SYSTEM_CLOCK 7
`define CMSR_F_STEP_UP 6
`define CMSR_F_SECOND_STEP_DOWN 4
`define CMSR_F_FIRST_STEP_DOWN 3
`define CMSR_F_SYNC_INPUT 2
`define CMSR_F_SWITCHER_SOURCE 1
`define CMSR_F_DIGITAL_SYSTEM 0

// ----------------------------------------------------------------
// warning register field positions
// ----------------------------------------------------------------
`define CMSR_W_STEP_UP 6
`define CMSR_W_SECOND_STEP_DOWN 4
`define CMSR_W_FIRST_STEP_DOWN 3
`define CMSR_W_SYNC_INPUT 2
`define CMSR_W_SWITCHER_SOURCE 1

// ----------------------------------------------------------------
// implemented bits, reset values, width
// ----------------------------------------------------------------
`define CMSR_REG_WIDTH 8
`define CMSR_FAULT_IMPL 8'hdf
`define CMSR_WARNING_IMPL 8'h5e
`define CMSR_FAULT_ACTION 8'hde
`define CMSR_RESET_VALUE 8'h00

`endif

//--- common/cmsr_pkg.sv
// types shared by the clock monitor status register bank
// assumes cmsr_cfg.svh is on the include path
`include "cmsr_cfg.svh"

package cmsr_pkg;

  typedef logic [`CMSR_REG_WIDTH-1:0] cmsr_byte_t;

  // ----------------------------------------------------------------
  // monitor results, one level per detected condition
  // ----------------------------------------------------------------
  typedef struct packed {
    logic system_clock_fault_analog;
    logic system_clock_fault_digital;
    logic step_up_switch_clock_fault;
    logic second_step_down_switch_clock_fault;
    logic first_step_down_switch_clock_fault;
    logic sync_input_clock_fault;
    logic switcher_source_clock_fault;
    logic digital_system_clock_fault;
  } cmsr_fault_s;

  typedef struct packed {
    logic step_up_switch_clock_warning;
    logic second_step_down_switch_clock_warning;
    logic first_step_down_switch_clock_warning;
    logic sync_input_clock_warning;
    logic switcher_source_clock_warning;
  } cmsr_warning_s;

  // ----------------------------------------------------------------
  // register command port
  // ----------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic write;
    logic sel;
  } cmsr_cmd_s;

  typedef struct packed {
    logic valid;
    logic refused;
    cmsr_byte_t data;
  } cmsr_rsp_s;

  typedef enum logic {
    CMSR_IDLE,
    CMSR_ANSWER
  } cmsr_state_e;

endpackage

//--- core/cmsr_flag_bank.sv
// one 8-bit bank of sticky status flags
// assumes set levels synchronous to core_clk and a one-cycle read pulse
`timescale 1ns/10ps
`include "cmsr_cfg.svh"

module cmsr_flag_bank #(
  parameter logic [`CMSR_REG_WIDTH-1:0] IMPL_MASK = `CMSR_FAULT_IMPL
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [`CMSR_REG_WIDTH-1:0] set_in,
  input wire logic read_pulse,
  output logic [`CMSR_REG_WIDTH-1:0] flags
);

  wire logic [`CMSR_REG_WIDTH-1:0] next_flags;

  // ----------------------------------------------------------------
  // per-bit next value
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < `CMSR_REG_WIDTH; i++) begin : g_bit
      if (IMPL_MASK[i]) begin : g_impl
        // a live condition wins over the clearing read, so no event is lost
        assign next_flags[i] = set_in[i] | (flags[i] & ~read_pulse);
      end else begin : g_rsvd
        assign next_flags[i] = 1'b0;
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // flag register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      flags <= `CMSR_RESET_VALUE;
    end else begin
      flags <= next_flags;
    end
  end

endmodule // cmsr_flag_bank

//--- test/cmsr_regs_props.sv
// checker of the clock monitor status register bank
// assumes it is bound to cmsr_regs and sees only its ports
`timescale 1ns/10ps
module cmsr_regs_props (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire cmsr_pkg::cmsr_fault_s fault_in,
  input wire cmsr_pkg::cmsr_warning_s warning_in,
  input wire cmsr_pkg::cmsr_cmd_s cmd,
  input wire logic cmd_ready,
  input wire cmsr_pkg::cmsr_rsp_s rsp,
  input wire cmsr_pkg::cmsr_byte_t fault_flags,
  input wire cmsr_pkg::cmsr_byte_t warning_flags,
  input wire logic clock_fault_pending,
  input wire logic clock_warning_pending
);
  // ------------------------------------------------
  // set levels mapped onto register positions
  // ------------------------------------------------
  logic [7:0] fs;
  logic [7:0] ws;
  assign fs = {fault_in[7] | fault_in[6], fault_in[5], 1'b0, fault_in[4:0]};
  assign ws = {1'b0, warning_in[4], 1'b0, warning_in[3:0], 1'b0};
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // the release edge still resets the design, so no attempt starts there
  sequence s_take; !sys_rst && cmd.valid && cmd_ready; endsequence
  sequence s_rd; !sys_rst && cmd.valid && cmd_ready && !cmd.write; endsequence
  sequence s_wr; !sys_rst && cmd.valid && cmd_ready && cmd.write; endsequence
  sequence s_answer; rsp.valid && !cmd_ready ##1 !rsp.valid && cmd_ready; endsequence
  property p_answer; s_take |=> s_answer; endproperty
  property p_refuse; s_wr |=> rsp.refused && rsp.data == 8'h00; endproperty
  property p_rdata;
    s_rd |=> !rsp.refused && rsp.data == $past(cmd.sel ? warning_flags : fault_flags);
  endproperty
  property p_clear;
    s_rd |=> ($past(cmd.sel) ? warning_flags == $past(ws) : fault_flags == $past(fs));
  endproperty
  property p_hold;
    !sys_rst && !cmd.valid |=> (fault_flags & $past(fault_flags)) == $past(fault_flags)
      && (warning_flags & $past(warning_flags)) == $past(warning_flags);
  endproperty
  property p_fset;
    !sys_rst |=> (fault_flags[7:3] & $past(fs[7:3])) == $past(fs[7:3]);
  endproperty
  property p_fset_low;
    !sys_rst |=> (fault_flags[2:0] & $past(fs[2:0])) == $past(fs[2:0]);
  endproperty
  property p_wset; !sys_rst |=> (warning_flags & $past(ws)) == $past(ws); endproperty
  property p_rsv; fault_flags[5] == 1'b0 && (warning_flags & 8'ha1) == 8'h00; endproperty
  property p_rst;
    disable iff (1'b0) sys_rst |=> fault_flags == 8'h00 && warning_flags == 8'h00 && !rsp.valid;
  endproperty
  property p_pend;
    !sys_rst |=> clock_fault_pending == $past(|fault_flags[7:1])
      && clock_warning_pending == $past(|warning_flags);
  endproperty
  a_answer: assert property (p_answer) else $error("answer timing wrong");
  a_refuse: assert property (p_refuse) else $error("write not refused");
  a_rdata: assert property (p_rdata) else $error("read data wrong");
  a_clear: assert property (p_clear) else $error("read clear wrong");
  a_hold: assert property (p_hold) else $error("flag lost without read");
  a_fset: assert property (p_fset) else $error("fault lost");
  a_fset_low: assert property (p_fset_low) else $error("fault lost");
  a_wset: assert property (p_wset) else $error("warning not latched");
  a_rsv: assert property (p_rsv) else $error("reserved bit set");
  a_rst: assert property (p_rst) else $error("reset value wrong");
  a_pend: assert property (p_pend) else $error("pending wrong");
endmodule // cmsr_regs_props

bind cmsr_regs cmsr_regs_props u_props (.core_clk, .sys_rst, .fault_in, .warning_in,
  .cmd, .cmd_ready, .rsp, .fault_flags, .warning_flags, .clock_fault_pending,
  .clock_warning_pending);

//--- test/cmsr_mcu_model.sv
// reading controller model on the register command port
// assumes the bench calls access, one command in flight at a time
`timescale 1ns/10ps
module cmsr_mcu_model (
  input wire logic core_clk,
  input wire logic cmd_ready,
  input wire cmsr_pkg::cmsr_rsp_s rsp,
  output cmsr_pkg::cmsr_cmd_s cmd
);
  initial cmd = '0;
  // writes are sent only when the bench asks, to provoke a refusal
  task automatic access(input logic wr, input logic sel, output logic [8:0] d);
    @(posedge core_clk);
    cmd <= '{1'b1, wr, sel};
    @(posedge core_clk);
    for (int i = 0; i < 8 && cmd_ready !== 1'b1; i++) @(posedge core_clk);
    cmd <= '0;
    @(posedge core_clk);
    d = rsp.valid === 1'b1 ? {rsp.refused, rsp.data} : 9'hxxx;
  endtask
endmodule // cmsr_mcu_model

//--- test/tb_clock_monitor_status_regs.sv
// testbench of the clock monitor status register bank
// assumes the checker binds itself and the controller model drives cmd
`timescale 1ns/10ps
module tb_clock_monitor_status_regs;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic rnd_on = 1'b0;
  cmsr_pkg::cmsr_fault_s fault_in = '0;
  cmsr_pkg::cmsr_warning_s warning_in = '0;
  cmsr_pkg::cmsr_cmd_s cmd;
  cmsr_pkg::cmsr_rsp_s rsp;
  cmsr_pkg::cmsr_byte_t fault_flags;
  cmsr_pkg::cmsr_byte_t warning_flags;
  logic cmd_ready, fp, wp;
  logic [31:0] seed = 32'hdb137fdf;
  logic [8:0] got;
  int fails = 0, samples_checked = 0, mf = 0, mw = 0, fs, ws, pf = 0, pw = 0;
  int exp_q[$];
  always #2 core_clk = ~core_clk;
  cmsr_regs dut (.core_clk, .sys_rst, .fault_in, .warning_in, .cmd, .cmd_ready, .rsp,
    .fault_flags, .warning_flags, .clock_fault_pending(fp), .clock_warning_pending(wp));
  cmsr_mcu_model mcu (.core_clk, .cmd_ready, .rsp, .cmd);
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task check(input string n, input logic [8:0] seen, input logic [8:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task results;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task acc(input logic wr, input logic sel);
    mcu.access(wr, sel, got);
    check("answer", got, 9'(exp_q.pop_front()));
  endtask
  // ------------------------------------------------
  // reference model, sticky flags kept as integers
  // ------------------------------------------------
  always @(posedge core_clk) begin
    fs = {fault_in[7] | fault_in[6], fault_in[5], 1'b0, fault_in[4:0]};
    ws = {1'b0, warning_in[4], 1'b0, warning_in[3:0], 1'b0};
    if (sys_rst) begin
      mf = 0;
      mw = 0;
      pf = 0;
      pw = 0;
    end else begin
      // summary levels follow the flags one edge late; masked bit 0 is left out
      pf = (mf & 254) != 0;
      pw = mw != 0;
      if (cmd.valid && cmd_ready) exp_q.push_back(cmd.write ? 256 : cmd.sel ? mw : mf);
      mf = fs | (mf & ((cmd.valid && cmd_ready && !cmd.write && !cmd.sel) ? 0 : 255));
      mw = ws | (mw & ((cmd.valid && cmd_ready && !cmd.write && cmd.sel) ? 0 : 255));
    end
    if (rnd_on) begin
      seed <= xs(seed);
      fault_in <= seed[7:0] & seed[15:8] & seed[23:16];
      warning_in <= seed[28:24] & seed[20:16];
    end
  end
  always @(negedge core_clk) begin
    check("fault_flags", {1'b0, fault_flags}, 9'(mf[7:0]));
    check("warning_flags", {1'b0, warning_flags}, 9'(mw[7:0]));
    check("pending", {7'h00, fp, wp}, {7'h00, pf[0], pw[0]});
  end
  initial begin
    #20000;
    fails++;
    results;
  end
  initial begin
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'b0;
    acc(1'b0, 1'b0);
    acc(1'b0, 1'b1);
    // conditions held across reads keep their flags, writes change nothing
    fault_in <= '1;
    warning_in <= '1;
    acc(1'b0, 1'b0);
    acc(1'b0, 1'b0);
    acc(1'b1, 1'b0);
    acc(1'b1, 1'b1);
    acc(1'b0, 1'b1);
    fault_in <= '0;
    warning_in <= '0;
    repeat (2) acc(1'b0, 1'b0);
    repeat (2) acc(1'b0, 1'b1);
    for (int b = 0; b < 8; b++) begin
      fault_in <= 8'h01 << b;
      warning_in <= 5'h01 << (b % 5);
      @(posedge core_clk);
      fault_in <= '0;
      warning_in <= '0;
      acc(1'b0, 1'b0);
      acc(1'b0, 1'b1);
    end
    rnd_on <= 1'b1;
    repeat (80) acc(seed[3:0] == 4'h0, seed[4]);
    // reset in mid-run must clear everything again
    sys_rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (10) acc(1'b0, seed[4]);
    results;
  end
endmodule // tb_clock_monitor_status_regs
